//--- hw/sigmon_params.svh
`ifndef SIGMON_PARAMS_SVH
`define SIGMON_PARAMS_SVH

// control register locations kept for software reference
`define MON_CTRL_OFFSET     16'h0270
`define MON_EMBED_OFFSET    16'h0279
`define MON_EMBED_EN_OFFSET 16'h027A
`define MON_ENABLE_BIT      1

// field widths and frame layout
`define PEAK_W              13
`define PERIOD_W            24
`define SAMPLE_W            16
`define FRAME_LEN           25
`define SUBFRAME_LEN        5
`define FRAME_CNT_W         5
`define MAG_SHIFT           3

// reset values
`define PRBS_SEED           15'h7FFF
`define PEAK_RESET          13'h0000
`define TIMER_RESET         24'h000000

// link limits
`define MAX_CTRL_BITS       3
`define MIN_RES             7
`define MAX_K               32
`define K_STEP              4

`endif

//--- hw/sigmon_pkg.sv
package sigmon_pkg;

  typedef enum logic [0:0] {
    MON_IDLE = 1'b0,
    MON_RUN  = 1'b1
  } mon_state_t;

  typedef enum logic [0:0] {
    TAIL_ZERO = 1'b0,
    TAIL_PRBS = 1'b1
  } tail_mode_t;

  typedef struct packed {
    mon_state_t  mode;
    logic [23:0] timer;
    logic [12:0] peak;
    logic        restart;
    logic [12:0] hold;
    logic [24:0] frame;
    logic [4:0]  bit_cnt;
    logic [14:0] prbs;
    logic [7:0]  lane0;
    logic [7:0]  lane1;
    logic [7:0]  lane2;
    logic [7:0]  lane3;
    logic        lane_valid;
    logic        cfg_ok;
    logic [7:0]  s_per;
    logic        hd;
  } mon_regs_t;

endpackage : sigmon_pkg

//--- hw/sample_packer.sv
`timescale 1ns/10ps
`include "sigmon_params.svh"

module sample_packer (
  input  wire logic [15:0] sample_i,
  input  wire logic [4:0]  resolution_i,
  input  wire logic [4:0]  word_size_i,
  input  wire logic [1:0]  ctrl_bits_i,
  input  wire logic [2:0]  ctrl_val_i,
  input  wire logic [15:0] tail_val_i,
  output logic      [15:0] word_o
);

  // word is left-justified: sample, then control bits, then tail
  always_comb begin
    word_o = 16'h0000;
    for (int i = 0; i < `SAMPLE_W; i++) begin
      if (i < int'(resolution_i)) begin
        word_o[15 - i] = sample_i[15 - i]; // R18
      end else if (i < int'(resolution_i) + int'(ctrl_bits_i)) begin
        word_o[15 - i] = ctrl_val_i[2 - (i - int'(resolution_i))]; // R10
      end else if (i < int'(word_size_i)) begin
        word_o[15 - i] = tail_val_i[i]; // R20 R19
      end
    end
  end

endmodule : sample_packer

//--- hw/peak_signal_monitor.sv
`timescale 1ns/10ps
`include "sigmon_params.svh"
// How it works
// R1 - track sample magnitude only, report the largest per period as 13 bits
// R2 - observation period is one 24-bit count of converter output samples
// R3 - peak detection runs only while the monitor enable bit is set
// R4 - host writes the period setting before enabling detection
// R5 - enabling loads the period into a timer that counts down per sample
// R6 - hidden peak store starts from current magnitude, keeps the greater
// R7 - at timer count 1 the peak moves into the readable holding register
// R8 - after transfer the timer reloads and the store restarts on next sample
// R9 - embedding needs select bits 1:0 and the embed enable bit together
// R10 - up to three control bits, filled from the most significant downward
// R11 - 25-bit frame, msb first, five 5-bit subframes each with start bit
// R12 - receiver deserialises control bits and matches link parameters
// R13 - two converters, or up to eight virtual ones, over 1 to 8 lanes
// R14 - lanes, converters 1,2,4,8; octets per frame 1,2,4,8,16
// R15 - word 8 or 16, resolution 7..16, control bits 0..3, K 4..32 by 4
// R16 - control words per frame zero; S and HD derived from L, M, F, N'
// R17 - default converter A on lanes 0,1 and B on lanes 2,3
// R18 - 14-bit sample: bits 13..6 first octet, 5..0 plus tail second
// R19 - tail bits zero or pseudorandom, or replaced by control flags
// R20 - tail bit count is word size less resolution less control bits
// R21 - holding register changes only when a period completes
// R22 - frame shifts one bit per sample, next frame after all 25 bits

module peak_signal_monitor (
  input  wire logic                    clock_i,
  input  wire logic                    nrst_i,
  input  wire logic                    sample_valid_i,
  input  wire logic [15:0]             sample_a_i,
  input  wire logic [15:0]             sample_b_i,
  input  wire logic [23:0]             monitor_period_setting_i,
  input  wire logic                    peak_enable_i,
  input  wire logic [1:0]              embed_select_i,
  input  wire logic                    embed_enable_i,
  input  wire logic [3:0]              lanes_i,
  input  wire logic [3:0]              converters_i,
  input  wire logic [4:0]              octets_i,
  input  wire logic [4:0]              word_size_i,
  input  wire logic [4:0]              resolution_i,
  input  wire logic [1:0]              ctrl_bits_i,
  input  wire logic [5:0]              frames_per_mf_i,
  input  wire sigmon_pkg::tail_mode_t  tail_mode_i,
  input  wire logic                    swap_ab_i,
  input  wire logic                    overrange_a_i,
  input  wire logic                    overrange_b_i,
  input  wire logic                    sysref_seen_i,
  input  wire logic                    fast_detect_a_i,
  input  wire logic                    fast_detect_b_i,
  output logic      [12:0]             hold_o,
  output logic      [7:0]              serial_lane_out_0_o,
  output logic      [7:0]              serial_lane_out_1_o,
  output logic      [7:0]              serial_lane_out_2_o,
  output logic      [7:0]              serial_lane_out_3_o,
  output logic                         lane_valid_o,
  output logic                         cfg_ok_o,
  output logic      [7:0]              s_per_o,
  output logic                         hd_o
);
  import sigmon_pkg::*;

  mon_regs_t   s;
  mon_regs_t   next_s;
  logic [12:0] mag;
  logic [12:0] cand;
  logic [23:0] reload_val;
  logic        running;
  logic        xfer;
  logic        embed;
  logic        frame_load;
  logic [24:0] new_frame;
  logic        mon_bit;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic [15:0] tail_val;

  // log2 of a power of two up to 16, flags non powers
  function automatic logic [3:0] lg2(input logic [4:0] v);
    unique case (v)
      5'h01:   lg2 = 4'h0;
      5'h02:   lg2 = 4'h1;
      5'h04:   lg2 = 4'h2;
      5'h08:   lg2 = 4'h3;
      5'h10:   lg2 = 4'h4;
      default: lg2 = 4'hF;
    endcase
  endfunction : lg2

  function automatic logic [12:0] magnitude(input logic [15:0] smp);
    logic [16:0] wide;
    wide = smp[15] ? (17'h00000 - {smp[15], smp}) : {1'b0, smp};
    magnitude = wide[15:3]; // R1
  endfunction : magnitude

  function automatic logic [12:0] max13(input logic [12:0] a, input logic [12:0] b);
    max13 = (a > b) ? a : b;
  endfunction : max13

  // five subframes: start bit then four payload bits, msb first
  function automatic logic [24:0] build_frame(input logic [12:0] pk);
    logic [19:0] pay;
    pay = {7'h00, pk};
    build_frame = '0;
    for (int i = 0; i < 5; i++) begin
      build_frame[24 - 5 * i -: 5] = {1'b1, pay[19 - 4 * i -: 4]}; // R11
    end
  endfunction : build_frame

  assign mag        = magnitude(sample_a_i);
  assign cand       = s.restart ? mag : max13(s.peak, mag);
  assign reload_val = (monitor_period_setting_i == 24'h000000) ? 24'h000001
                    : monitor_period_setting_i;
  assign running    = (s.mode == MON_RUN) && peak_enable_i;
  assign xfer       = running && sample_valid_i && (s.timer == 24'h000001); // R7
  assign embed      = (embed_select_i == 2'b11) && embed_enable_i; // R9
  assign frame_load = embed && sample_valid_i && (s.bit_cnt <= 5'h01);
  assign new_frame  = build_frame(s.hold);
  assign mon_bit    = (s.bit_cnt != 5'h00) ? s.frame[24] : 1'b0;
  assign tail_val   = (tail_mode_i == TAIL_PRBS) ? {s.prbs, s.prbs[14]} : 16'h0000; // R19

  sample_packer pack_a (
    .sample_i     (sample_a_i),
    .resolution_i (resolution_i),
    .word_size_i  (word_size_i),
    .ctrl_bits_i  (ctrl_bits_i),
    .ctrl_val_i   ({embed ? mon_bit : overrange_a_i, sysref_seen_i, fast_detect_a_i}), // R10
    .tail_val_i   (tail_val),
    .word_o       (word_a)
  );

  sample_packer pack_b (
    .sample_i     (sample_b_i),
    .resolution_i (resolution_i),
    .word_size_i  (word_size_i),
    .ctrl_bits_i  (ctrl_bits_i),
    .ctrl_val_i   ({embed ? mon_bit : overrange_b_i, sysref_seen_i, fast_detect_b_i}),
    .tail_val_i   (tail_val),
    .word_o       (word_b)
  );

  always_comb begin
    logic [3:0] l2l;
    logic [3:0] l2m;
    logic [3:0] l2f;
    logic [3:0] l2n;
    logic [5:0] num;
    logic [5:0] den;
    l2l    = lg2({1'b0, lanes_i});
    l2m    = lg2({1'b0, converters_i});
    l2f    = lg2(octets_i);
    l2n    = lg2(word_size_i);
    num    = 6'(l2f) + 6'(l2l) + 6'h03;
    den    = 6'(l2m) + 6'(l2n);
    next_s = s;

    // monitor timer and peak store
    if (!peak_enable_i) begin
      next_s.mode    = MON_IDLE; // R3
      next_s.restart = 1'b1;
    end else if (sample_valid_i) begin
      if (s.mode == MON_IDLE) begin
        next_s.mode    = MON_RUN;
        next_s.timer   = reload_val; // R5 R4
        next_s.peak    = mag; // R6
        next_s.restart = 1'b0;
      end else if (xfer) begin
        next_s.hold    = cand; // R7 R21
        next_s.timer   = reload_val; // R8 R2
        next_s.restart = 1'b1; // R8
      end else begin
        next_s.timer   = s.timer - 24'h000001; // R5
        next_s.peak    = cand; // R6
        next_s.restart = 1'b0;
      end
    end

    // serial monitor frame, one bit per sample
    if (!embed) begin
      next_s.bit_cnt = 5'h00;
    end else if (frame_load) begin
      next_s.frame   = new_frame; // R22
      next_s.bit_cnt = 5'(`FRAME_LEN);
    end else if (sample_valid_i) begin
      next_s.frame   = {s.frame[23:0], 1'b0}; // R22
      next_s.bit_cnt = s.bit_cnt - 5'h01;
    end

    // tail sequence and lane octets
    if (sample_valid_i) begin
      next_s.prbs       = {s.prbs[13:0], s.prbs[14] ^ s.prbs[13]};
      next_s.lane0      = swap_ab_i ? word_b[15:8] : word_a[15:8]; // R17 R18
      next_s.lane1      = swap_ab_i ? word_b[7:0]  : word_a[7:0];
      next_s.lane2      = swap_ab_i ? word_a[15:8] : word_b[15:8]; // R17
      next_s.lane3      = swap_ab_i ? word_a[7:0]  : word_b[7:0];
    end
    next_s.lane_valid = sample_valid_i;

    // link parameter check and derived values
    next_s.cfg_ok = (l2l <= 4'h3) && (l2m <= 4'h3) && (l2f <= 4'h4) // R14 R13
                  && ((word_size_i == 5'h08) || (word_size_i == 5'h10)) // R15
                  && (resolution_i >= 5'(`MIN_RES))
                  && (6'(resolution_i) + 6'(ctrl_bits_i) <= 6'(word_size_i)) // R20
                  && (frames_per_mf_i[1:0] == 2'b00)
                  && (frames_per_mf_i != 6'h00)
                  && (frames_per_mf_i <= 6'(`MAX_K))
                  && (num >= den); // R16
    next_s.s_per  = (num >= den) ? (8'h01 << 3'(num - den)) : 8'h00; // R16
    next_s.hd     = (6'(l2f) + 6'h03 < 6'(l2n)); // R16
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s            <= '0;
      s.mode       <= MON_IDLE;
      s.timer      <= `TIMER_RESET;
      s.peak       <= `PEAK_RESET;
      s.hold       <= `PEAK_RESET;
      s.restart    <= 1'b1;
      s.prbs       <= `PRBS_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign hold_o              = s.hold;
  assign serial_lane_out_0_o = s.lane0;
  assign serial_lane_out_1_o = s.lane1;
  assign serial_lane_out_2_o = s.lane2;
  assign serial_lane_out_3_o = s.lane3;
  assign lane_valid_o        = s.lane_valid;
  assign cfg_ok_o            = s.cfg_ok;
  assign s_per_o             = s.s_per;
  assign hd_o                = s.hd;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  a_idle_when_off: assert property (!peak_enable_i |=> s.mode == MON_IDLE) // R3
    else $error("monitor still running while disabled");

  a_enable_load: assert property ( // R5
    (peak_enable_i && sample_valid_i && s.mode == MON_IDLE)
    |=> (s.timer == $past(reload_val)) && (s.peak == $past(mag)))
    else $error("timer or peak not loaded on enable");

  a_timer_count: assert property ( // R5
    (running && sample_valid_i && s.timer > 24'h000001)
    |=> s.timer == $past(s.timer) - 24'h000001)
    else $error("period timer did not decrement");

  a_peak_greater: assert property ( // R6
    (running && sample_valid_i && !xfer && !s.restart)
    |=> (s.peak >= $past(s.peak)) && (s.peak >= $past(mag)))
    else $error("peak store lost a larger magnitude");

  a_hold_xfer: assert property (xfer |=> s.hold == $past(cand)) // R7
    else $error("holding register not loaded at count one");

  a_hold_stable: assert property ((s.hold != $past(s.hold)) |-> $past(xfer)) // R21
    else $error("holding register changed mid period");

  a_reload_restart: assert property ( // R8
    xfer |=> (s.timer == $past(reload_val)) && s.restart)
    else $error("timer not reloaded after transfer");

  a_frame_starts: assert property ( // R11
    frame_load |=> s.frame[24] && s.frame[19] && s.frame[14] && s.frame[9] && s.frame[4]
                   && s.bit_cnt == 5'h19)
    else $error("frame start bits missing");

  a_frame_shift: assert property ( // R22
    (embed && sample_valid_i && s.bit_cnt > 5'h01)
    |=> (s.frame == {$past(s.frame[23:0]), 1'b0})
        && (s.bit_cnt == $past(s.bit_cnt) - 5'h01))
    else $error("frame bit not shifted per sample");

  a_embed_gate: assert property (!embed |=> s.bit_cnt == 5'h00) // R9
    else $error("frame running without embed enable");

  a_lane_valid: assert property (sample_valid_i |=> lane_valid_o) // R18
    else $error("lane octets not flagged after a sample");

  a_lane_stable: assert property ( // R17
    !sample_valid_i |=> $stable(s.lane0) && $stable(s.lane1) && $stable(s.lane2))
    else $error("lane octets moved without a sample");

  a_lanes_legal: assert property ( // R14
    !(lanes_i inside {4'h1, 4'h2, 4'h4, 4'h8}) |=> !s.cfg_ok)
    else $error("illegal lane count accepted");

  a_octets_legal: assert property ( // R14
    !(octets_i inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10}) |=> !s.cfg_ok)
    else $error("illegal octet count accepted");

  a_res_range: assert property ((resolution_i < 5'(`MIN_RES)) |=> !s.cfg_ok) // R15
    else $error("resolution below range accepted");

  a_word_fit: assert property ( // R20
    (6'(resolution_i) + 6'(ctrl_bits_i) > 6'(word_size_i)) |=> !s.cfg_ok)
    else $error("sample and control bits overflow the word");

  a_k_range: assert property ((frames_per_mf_i > 6'(`MAX_K)) |=> !s.cfg_ok) // R15
    else $error("frames per multiframe above range accepted");

endmodule : peak_signal_monitor

//--- testbench/mon_receiver.sv
`timescale 1ns/10ps

module mon_receiver (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        arm_i,
  input  wire logic        lane_valid_i,
  input  wire logic [7:0]  lane_lo_i,
  output logic      [24:0] frame_o,
  output logic             frame_valid_o
);
  logic [23:0] shift;
  logic [4:0]  cnt;

  // hunt for the first start bit, then take 25 control bits per frame
  always @(posedge clock_i) begin
    frame_valid_o <= 1'b0;
    if (!nrst_i || !arm_i) begin
      cnt <= 5'h00;
    end else if (lane_valid_i && (cnt != 5'h00 || lane_lo_i[1])) begin
      shift <= {shift[22:0], lane_lo_i[1]};
      if (cnt == 5'h18) begin
        frame_o       <= {shift, lane_lo_i[1]};
        frame_valid_o <= 1'b1;
        cnt           <= 5'h00;
      end else begin
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule : mon_receiver

//--- testbench/test_peak_signal_monitor.sv
`timescale 1ns/10ps

module test_peak_signal_monitor;
  import sigmon_pkg::*;
  logic        clock_i, nrst_i, valid, pen, sen, swap, arm, ora, orb, lv, ok, fv, run, rs;
  logic [15:0] sa, sb;
  logic [23:0] per;
  logic [1:0]  sel, cs;
  logic [3:0]  l, m;
  logic [4:0]  f, np, n;
  logic [5:0]  k;
  logic [12:0] hold, pk;
  logic [12:0] last     = 13'h0000;
  logic [12:0] exp_last = 13'h0000;
  logic [31:0] lanes;
  logic [24:0] frame;
  logic [7:0]  sp;
  logic        hdv;
  logic [9:0]  ce;
  logic [14:0] pr = 15'h7FFF;
  tail_mode_t  tm = TAIL_ZERO;
  logic [31:0] lq[$];
  logic [24:0] fq[$];
  logic [12:0] hq[$];
  logic [9:0]  cq[$];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed = 32'hD402;
  int          cyc = 0;
  int          tmr;
  int          pl[4] = '{5, 1, 0, 13};

  peak_signal_monitor i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .sample_valid_i(valid), .sample_a_i(sa),
    .sample_b_i(sb), .monitor_period_setting_i(per), .peak_enable_i(pen),
    .embed_select_i(sel), .embed_enable_i(sen), .lanes_i(l), .converters_i(m),
    .octets_i(f), .word_size_i(np), .resolution_i(n), .ctrl_bits_i(cs),
    .frames_per_mf_i(k), .tail_mode_i(tm), .swap_ab_i(swap),
    .overrange_a_i(ora), .overrange_b_i(orb), .sysref_seen_i(1'b0),
    .fast_detect_a_i(1'b0), .fast_detect_b_i(1'b0), .hold_o(hold),
    .serial_lane_out_0_o(lanes[31:24]), .serial_lane_out_1_o(lanes[23:16]),
    .serial_lane_out_2_o(lanes[15:8]), .serial_lane_out_3_o(lanes[7:0]),
    .lane_valid_o(lv), .cfg_ok_o(ok), .s_per_o(sp), .hd_o(hdv)
  );

  mon_receiver i_rx (
    .clock_i(clock_i), .nrst_i(nrst_i), .arm_i(arm), .lane_valid_i(lv),
    .lane_lo_i(lanes[23:16]), .frame_o(frame), .frame_valid_o(fv)
  );

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_hold(input logic [12:0] got, exp);
    cmp(32'(got), 32'(exp));
  endtask : cmp_hold

  task automatic cmp_lanes(input logic [31:0] got, exp);
    cmp(got, exp);
  endtask : cmp_lanes

  task automatic cmp_frame(input logic [24:0] got, exp);
    cmp(32'(got), 32'(exp));
  endtask : cmp_frame

  task automatic cmp_cfg(input logic [9:0] got, exp);
    cmp(32'(got), 32'(exp));
  endtask : cmp_cfg

  // results are taken off the note queues once settled
  always @(negedge clock_i) begin
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      finish_test();
    end
    if (nrst_i && hold !== last) begin
      if (hq.size() == 0) cmp_hold(hold, last);
      else cmp_hold(hold, hq.pop_front());
      last = hold;
    end
    if (lv && lq.size() > 0) cmp_lanes(lanes, lq.pop_front());
    if (fv) cmp_frame(frame, (fq.size() > 0) ? fq.pop_front() : ~frame);
    if (cq.size() > 0) begin
      ce = cq.pop_front();
      cmp_cfg(ce[9] ? {ok, sp, hdv} : {ok, 9'h000}, ce);
    end
  end

  // legal sets also carry S = 8*F*L/(M*N') and HD = (F*8 < N')
  task automatic cfg(input int il, im, ifr, inp, ir, ics, ik, iok);
    {l, m, f, np, n, cs, k} <= {4'(il), 4'(im), 5'(ifr), 5'(inp), 5'(ir), 2'(ics), 6'(ik)};
    repeat (2) @(posedge clock_i);
    if (iok != 0) cq.push_back({1'b1, 8'(8 * ifr * il / (im * inp)), 1'(ifr * 8 < inp)});
    else cq.push_back(10'h000);
    @(posedge clock_i);
  endtask : cfg

  task automatic put(input logic [15:0] a);
    logic [15:0] b, ab, wa, wb;
    logic        o, tb;
    b = 16'($random(seed));
    o = 1'($random(seed));
    ab = a[15] ? -a : a;
    tb = (tm == TAIL_PRBS) ? pr[14] : 1'b0;
    pr = {pr[13:0], pr[14] ^ pr[13]};
    wa = {a[15:2], o, tb};
    wb = {b[15:2], ~o, tb};
    valid <= 1'b1;
    sa <= a;
    sb <= b;
    ora <= o;
    orb <= ~o;
    if (!(sen && sel == 2'h3)) lq.push_back(swap ? {wb, wa} : {wa, wb});
    if (pen && !run) begin
      pk = ab[15:3];
      tmr = (per == 24'h000000) ? 1 : int'(per);
      rs = 1'b0;
      run = 1'b1;
    end else if (pen) begin
      pk = (rs || ab[15:3] > pk) ? ab[15:3] : pk;
      rs = 1'b0;
      if (tmr == 1) begin
        if (pk !== exp_last) hq.push_back(pk);
        exp_last = pk;
        tmr = (per == 24'h000000) ? 1 : int'(per);
        rs = 1'b1;
      end else tmr--;
    end
    @(posedge clock_i);
    if (1'($random(seed))) begin
      valid <= 1'b0;
      @(posedge clock_i);
    end
  endtask : put

  initial begin
    {valid, pen, sen, swap, arm, ora, orb, run, rs} = '0;
    {sa, sb, per, sel} = '0;
    {l, m, f, np, n, cs, k} = {4'h4, 4'h2, 5'h02, 5'h10, 5'h0E, 2'h1, 6'h20};
    nrst_i = 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    cfg(3, 2, 2, 16, 14, 1, 32, 0);
    cfg(8, 8, 16, 16, 16, 0, 4, 1);
    cfg(4, 2, 3, 16, 14, 1, 32, 0);
    cfg(1, 1, 1, 8, 7, 1, 8, 1);
    cfg(1, 1, 1, 8, 6, 0, 8, 0);
    cfg(4, 2, 2, 16, 14, 1, 6, 0);
    cfg(4, 2, 2, 16, 14, 1, 36, 0);
    cfg(1, 1, 1, 8, 8, 1, 8, 0);
    cfg(8, 4, 1, 16, 14, 1, 32, 1);
    cfg(4, 2, 2, 16, 14, 1, 32, 1);
    foreach (pl[i]) begin
      per <= 24'(pl[i]);
      swap <= pl[i][0];
      tm <= tail_mode_t'(pl[i][2]);
      @(posedge clock_i);
      pen <= 1'b1;
      @(posedge clock_i);
      repeat (3 * pl[i] + 9) put(16'($random(seed)));
      valid <= 1'b0;
      pen <= 1'b0;
      @(posedge clock_i);
      run = 1'b0;
    end
    for (int s = 0; s < 4; s++) begin
      {valid, swap} <= 2'h0;
      sel <= 2'(s);
      sen <= 1'b1;
      arm <= (s == 3);
      repeat (2) @(posedge clock_i);
      if (s == 3) repeat (2) fq.push_back({1'b1, 4'h0, 1'b1, 3'h0, exp_last[12], 1'b1,
        exp_last[11:8], 1'b1, exp_last[7:4], 1'b1, exp_last[3:0]});
      repeat (60) put(16'($random(seed)));
      {valid, arm, sen} <= 3'h0;
      repeat (2) @(posedge clock_i);
    end
    repeat (3) @(posedge clock_i);
    cmp(32'(hq.size() + fq.size() + cq.size() + lq.size()), 32'h0);
    finish_test();
  end
endmodule : test_peak_signal_monitor
